// ===== include/rom_patch_pkg.sv
package rom_patch_pkg;

  // Address space and data widths
  localparam int ADDR_W = 20;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 24;
  localparam int NUM_BANKS = 4;
  localparam int SLOTS_PER_BANK = 6;
  localparam int WDC_W = 5;
  localparam int BANK_W = 2;
  localparam int SLOT_W = 3;

  // Register map
  localparam logic [ADDR_W-1:0] PATCH_DATA_PORT_ADDR = 20'h0_0FE2;
  localparam logic [ADDR_W-1:0] PATCH_CONTROL_ADDR = 20'h0_0FE3;
  localparam logic [BYTE_W-1:0] PATCH_DATA_PORT_RESET = 8'h00;
  localparam logic [NUM_BANKS-1:0] PATCH_CONTROL_RESET = 4'h0;

  // Write byte counter figures
  localparam logic [WDC_W-1:0] WDC_RESET = 5'h00;
  localparam logic [WDC_W-1:0] WDC_LAST = 5'h17;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;
  localparam logic [BANK_W-1:0] BANK_FIRST = 2'h0;

  // Slot order inside a bank
  localparam logic [SLOT_W-1:0] SLOT_ADDR_LO = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_ADDR_MID = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_ADDR_HI = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_DATA_LO = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_DATA_MID = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_DATA_HI = 3'h5;
  localparam int ADDR_HI_W = 4;

  // Memory regions that trap on fetch
  localparam logic [ADDR_W-1:0] SFR_LO = 20'h0_0000;
  localparam logic [ADDR_W-1:0] SFR_HI = 20'h0_003F;
  localparam logic [ADDR_W-1:0] RAM_LO = 20'h0_0040;
  localparam logic [ADDR_W-1:0] RAM_HI = 20'h0_06BF;
  localparam logic [ADDR_W-1:0] DBR_LO = 20'h0_0F80;
  localparam logic [ADDR_W-1:0] DBR_HI = 20'h0_0FFF;
  localparam logic [ADDR_W-1:0] WINDOW_LO = 20'h0_02C0;
  localparam logic [ADDR_W-1:0] WINDOW_HI = 20'h0_06BF;

  // Trap reset pulse timing
  localparam int CLK_MHZ = 125;
  localparam int TRAP_MIN_NS = 500;
  localparam int TRAP_MAX_NS = 1500;
  localparam int TRAP_CYCLES = (TRAP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int TRAP_CNT_W = 8;

  // Read sizes
  localparam logic [1:0] SIZE_ONE = 2'h1;
  localparam logic [1:0] SIZE_TWO = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  typedef struct packed {
    logic strobe;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } write_req_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } fetch_req_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic ptr_update;
  } read_req_type;

  typedef struct packed {
    logic redirect;
    logic [ADDR_W-1:0] target;
  } jump_type;

endpackage

// ===== rtl/patch_bank.sv
`timescale 1ns/1ps
module patch_bank (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Loading
  input wire logic wr_in,
  input wire logic [rom_patch_pkg::SLOT_W-1:0] slot_in,
  input wire logic [rom_patch_pkg::BYTE_W-1:0] byte_in,
  // Compare
  input wire logic [rom_patch_pkg::ADDR_W-1:0] fetch_addr_in,
  input wire logic [rom_patch_pkg::ADDR_W-1:0] read_addr_in,
  output logic loaded_out,
  output logic fetch_match_out,
  output logic read_match_out,
  output logic [rom_patch_pkg::DATA_W-1:0] payload_out
);

  logic [rom_patch_pkg::ADDR_W-1:0] start_q;
  logic [rom_patch_pkg::ADDR_W-1:0] start_d;
  logic [rom_patch_pkg::DATA_W-1:0] payload_q;
  logic [rom_patch_pkg::DATA_W-1:0] payload_d;
  logic loaded_q;
  logic loaded_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    start_d = start_q;
    payload_d = payload_q;
    loaded_d = loaded_q;
    if (wr_in) begin
      case (slot_in) // RULE11
        rom_patch_pkg::SLOT_ADDR_LO: start_d[7:0] = byte_in;
        rom_patch_pkg::SLOT_ADDR_MID: start_d[15:8] = byte_in;
        rom_patch_pkg::SLOT_ADDR_HI: begin
          start_d[19:16] = byte_in[rom_patch_pkg::ADDR_HI_W-1:0];
        end
        rom_patch_pkg::SLOT_DATA_LO: payload_d[7:0] = byte_in;
        rom_patch_pkg::SLOT_DATA_MID: payload_d[15:8] = byte_in;
        rom_patch_pkg::SLOT_DATA_HI: begin
          payload_d[23:16] = byte_in;
          loaded_d = 1'b1;
        end
        default: loaded_d = loaded_q;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_q <= '0;
      payload_q <= '0;
      loaded_q <= 1'b0;
    end else if (ce_in) begin
      start_q <= start_d;
      payload_q <= payload_d;
      loaded_q <= loaded_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only fully loaded banks compare; a half written address never hits on the first load
  assign loaded_out = loaded_q;
  assign fetch_match_out = loaded_q && (fetch_addr_in == start_q); // RULE19
  assign read_match_out = loaded_q && (read_addr_in == start_q); // RULE19
  assign payload_out = payload_q;

endmodule

// ===== rtl/rom_patch_unit.sv
`timescale 1ns/1ps
// Function
// RULE1: Four independent banks, each patching one ROM location at once.
// RULE2: Each bank redirects a fetch or substitutes up to three data bytes.
// RULE3: Per-bank mode select bits 0..3 sit in the patch control register.
// RULE4: After reset the unit is disabled and alters nothing.
// RULE5: Unit enables once one bank's full six bytes are written.
// RULE6: When enabled, fetches from RAM 02C0H..06BFH do not trap.
// RULE7: Software cannot disable the unit; only reset does.
// RULE8: Fetch from RAM, data buffer or special area raises trap reset.
// RULE9: Each data port write stores into the counter's slot, then increments.
// RULE10: Reset clears the write byte counter so bank 0 fills first.
// RULE11: Software writes address low, mid, upper, then data low, mid, upper.
// RULE12: Counter equals bytes stored, 1..23, and wraps to 0 on 24th.
// RULE13: Software keeps bank start addresses over five apart.
// RULE14: Software never patches an idle-mode instruction address.
// RULE15: Redirect mode turns a fetch at the start address into a jump.
// RULE16: Mode bit 0 selects redirect, 1 selects data substitution.
// RULE17: Substitution replaces the first one, two or three bytes read.
// RULE18: Post-increment or pre-decrement pointer reads are never substituted.
// RULE19: Compare against loaded banks combinationally, adding no wait cycles.
module rom_patch_unit #(
  parameter logic [rom_patch_pkg::ADDR_W-1:0] RAM_LO = rom_patch_pkg::RAM_LO,
  parameter logic [rom_patch_pkg::ADDR_W-1:0] RAM_HI = rom_patch_pkg::RAM_HI
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // CPU register writes
  input wire rom_patch_pkg::write_req_type wr_in,
  // Instruction fetch path
  input wire rom_patch_pkg::fetch_req_type fetch_in,
  output rom_patch_pkg::jump_type jump_out,
  // Data read path
  input wire rom_patch_pkg::read_req_type read_in,
  input wire logic [rom_patch_pkg::DATA_W-1:0] rom_data_in,
  output logic [rom_patch_pkg::DATA_W-1:0] read_data_out,
  output logic read_patched_out,
  // Status
  output logic enabled_out,
  output logic [rom_patch_pkg::NUM_BANKS-1:0] mode_out,
  output logic [rom_patch_pkg::WDC_W-1:0] write_count_out,
  // Reset pin, open drain
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  output logic trap_out
);

  localparam int NB = rom_patch_pkg::NUM_BANKS;
  localparam int TRAP_LEN = rom_patch_pkg::TRAP_CYCLES;
  localparam logic [rom_patch_pkg::TRAP_CNT_W-1:0] TRAP_LOAD =
    rom_patch_pkg::TRAP_CNT_W'(TRAP_LEN);

  function automatic logic in_range(
    input logic [rom_patch_pkg::ADDR_W-1:0] a,
    input logic [rom_patch_pkg::ADDR_W-1:0] lo,
    input logic [rom_patch_pkg::ADDR_W-1:0] hi
  );
    in_range = (a >= lo) && (a <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Loading state
  logic [rom_patch_pkg::WDC_W-1:0] wdc_q;
  logic [rom_patch_pkg::WDC_W-1:0] wdc_d;
  logic [rom_patch_pkg::BANK_W-1:0] bank_q;
  logic [rom_patch_pkg::BANK_W-1:0] bank_d;
  logic [rom_patch_pkg::SLOT_W-1:0] slot_q;
  logic [rom_patch_pkg::SLOT_W-1:0] slot_d;
  logic [NB-1:0] mode_q;
  logic [NB-1:0] mode_d;
  logic enabled_q;
  logic enabled_d;
  logic data_wr;
  logic ctrl_wr;
  logic [NB-1:0] loaded;

  assign data_wr = wr_in.strobe &&
    (wr_in.addr == rom_patch_pkg::PATCH_DATA_PORT_ADDR);
  assign ctrl_wr = wr_in.strobe &&
    (wr_in.addr == rom_patch_pkg::PATCH_CONTROL_ADDR);

  always_comb begin
    wdc_d = wdc_q;
    bank_d = bank_q;
    slot_d = slot_q;
    mode_d = mode_q;
    enabled_d = enabled_q;
    if (ctrl_wr) begin
      mode_d = wr_in.data[NB-1:0]; // RULE3
    end
    if (data_wr) begin
      if (wdc_q == rom_patch_pkg::WDC_LAST) begin
        wdc_d = rom_patch_pkg::WDC_RESET; // RULE12
      end else begin
        wdc_d = wdc_q + 1'b1; // RULE9
      end
      if (slot_q == rom_patch_pkg::SLOT_LAST) begin
        slot_d = rom_patch_pkg::SLOT_FIRST;
        bank_d = bank_q + 1'b1;
      end else begin
        slot_d = slot_q + 1'b1;
      end
    end
    // Sticky: no write path clears it
    if (|loaded) begin
      enabled_d = 1'b1; // RULE5 RULE7
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdc_q <= rom_patch_pkg::WDC_RESET; // RULE10
      bank_q <= rom_patch_pkg::BANK_FIRST;
      slot_q <= rom_patch_pkg::SLOT_FIRST;
      mode_q <= rom_patch_pkg::PATCH_CONTROL_RESET;
      enabled_q <= 1'b0; // RULE4
    end else if (ce_in) begin
      wdc_q <= wdc_d;
      bank_q <= bank_d;
      slot_q <= slot_d;
      mode_q <= mode_d;
      enabled_q <= enabled_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banks
  logic [NB-1:0] fetch_match;
  logic [NB-1:0] read_match;
  logic [rom_patch_pkg::DATA_W-1:0] payload [NB];

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : gen_bank
      patch_bank u_bank ( // RULE1
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .wr_in(data_wr && (bank_q == rom_patch_pkg::BANK_W'(g))), // RULE9
        .slot_in(slot_q),
        .byte_in(wr_in.data),
        .fetch_addr_in(fetch_in.addr),
        .read_addr_in(read_in.addr),
        .loaded_out(loaded[g]),
        .fetch_match_out(fetch_match[g]),
        .read_match_out(read_match[g]),
        .payload_out(payload[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Fetch redirect and data substitution, lowest bank wins on overlap
  always_comb begin
    jump_out = '0;
    read_data_out = rom_data_in;
    read_patched_out = 1'b0;
    if (enabled_q) begin // RULE4
      for (int i = NB - 1; i >= 0; i--) begin
        if (fetch_in.valid && fetch_match[i] && !mode_q[i]) begin // RULE16
          jump_out.redirect = 1'b1; // RULE15 RULE2
          jump_out.target = payload[i][rom_patch_pkg::ADDR_W-1:0];
        end
      end
      for (int i = NB - 1; i >= 0; i--) begin
        if (read_in.valid && read_match[i] && mode_q[i] &&
            !read_in.ptr_update) begin // RULE16 RULE18
          read_patched_out = 1'b1; // RULE2
          read_data_out = rom_data_in;
          read_data_out[7:0] = payload[i][7:0]; // RULE17
          if (read_in.size != rom_patch_pkg::SIZE_ONE) begin
            read_data_out[15:8] = payload[i][15:8]; // RULE17
          end
          if (read_in.size == rom_patch_pkg::SIZE_THREE) begin
            read_data_out[23:16] = payload[i][23:16]; // RULE17
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address trap reset; the pulse uses the shortest legal length
  logic [rom_patch_pkg::TRAP_CNT_W-1:0] trap_cnt_q;
  logic [rom_patch_pkg::TRAP_CNT_W-1:0] trap_cnt_d;
  logic trap_hit;
  logic in_window;

  assign in_window = enabled_q && in_range(fetch_in.addr,
    rom_patch_pkg::WINDOW_LO, rom_patch_pkg::WINDOW_HI); // RULE6
  assign trap_hit = fetch_in.valid && !in_window &&
    (in_range(fetch_in.addr, rom_patch_pkg::SFR_LO, rom_patch_pkg::SFR_HI) ||
     in_range(fetch_in.addr, RAM_LO, RAM_HI) ||
     in_range(fetch_in.addr, rom_patch_pkg::DBR_LO,
       rom_patch_pkg::DBR_HI)); // RULE8

  always_comb begin
    trap_cnt_d = trap_cnt_q;
    if (trap_cnt_q != '0) begin
      trap_cnt_d = trap_cnt_q - 1'b1;
    end else if (trap_hit) begin
      trap_cnt_d = TRAP_LOAD; // RULE8
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trap_cnt_q <= '0;
    end else if (ce_in) begin
      trap_cnt_q <= trap_cnt_d;
    end
  end

  assign trap_out = (trap_cnt_q != '0);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_out = trap_out; // RULE8
  assign enabled_out = enabled_q;
  assign mode_out = mode_q;
  assign write_count_out = wdc_q;

endmodule

// ===== dv/rom_image_model.sv
`timescale 1ns/1ps
module rom_image_model (
  // Read address
  input wire logic [rom_patch_pkg::ADDR_W-1:0] addr_in,
  // Bytes at addr, addr+1, addr+2
  output logic [rom_patch_pkg::DATA_W-1:0] data_out
);
  // Content follows the address so neighbours differ
  assign data_out = {addr_in[7:0] + 8'h02, addr_in[7:0] + 8'h01,
    addr_in[7:0]};
endmodule

// ===== dv/rom_patch_unit_assertions.sv
`timescale 1ns/1ps
module rom_patch_unit_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire rom_patch_pkg::write_req_type wr_in,
  input wire rom_patch_pkg::fetch_req_type fetch_in,
  input wire rom_patch_pkg::jump_type jump_out,
  input wire rom_patch_pkg::read_req_type read_in,
  input wire logic [rom_patch_pkg::DATA_W-1:0] rom_data_in,
  input wire logic [rom_patch_pkg::DATA_W-1:0] read_data_out,
  input wire logic read_patched_out,
  input wire logic enabled_out,
  input wire logic [rom_patch_pkg::NUM_BANKS-1:0] mode_out,
  input wire logic [rom_patch_pkg::WDC_W-1:0] write_count_out,
  input wire logic trap_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic port_wr, ctl_wr;
  logic [7:0] pulse_q, pulse_d;
  assign port_wr = ce_in && wr_in.strobe &&
    wr_in.addr == rom_patch_pkg::PATCH_DATA_PORT_ADDR;
  assign ctl_wr = ce_in && wr_in.strobe &&
    wr_in.addr == rom_patch_pkg::PATCH_CONTROL_ADDR;
  // Saturates so a stuck pulse cannot wrap into a match
  always_comb pulse_d = !trap_out ? 8'h00 : pulse_q + {7'h00, ~&pulse_q};
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) pulse_q <= 8'h00;
    else pulse_q <= pulse_d;
  cnt_step_a: assert property (port_wr |=> write_count_out ==
    ($past(write_count_out) == rom_patch_pkg::WDC_LAST ? 5'h00 :
    $past(write_count_out) + 5'h01)) else $error("count step wrong");
  cnt_hold_a: assert property (!port_wr |=> $stable(write_count_out))
    else $error("count moved without write");
  mode_wr_a: assert property (ctl_wr |=> mode_out == $past(wr_in.data[3:0]))
    else $error("mode bits not stored");
  en_stick_a: assert property (enabled_out |=> enabled_out)
    else $error("unit disabled without reset");
  off_clean_a: assert property (!enabled_out |->
    !jump_out.redirect && !read_patched_out) else $error("patch while off");
  en_late_a: assert property (port_wr && write_count_out == 5'h05
    |=> ##1 enabled_out) else $error("not enabled after bank");
  ptr_raw_a: assert property (read_in.ptr_update |->
    !read_patched_out && read_data_out == rom_data_in)
    else $error("pointer read substituted");
  win_safe_a: assert property (enabled_out && ce_in && fetch_in.valid &&
    fetch_in.addr inside {[rom_patch_pkg::WINDOW_LO:rom_patch_pkg::WINDOW_HI]}
    && !trap_out |=> !trap_out) else $error("window fetch trapped");
  sfr_trap_a: assert property (ce_in && fetch_in.valid && !trap_out &&
    fetch_in.addr <= rom_patch_pkg::SFR_HI |=> trap_out)
    else $error("special area fetch missed");
  pulse_len_a: assert property ($fell(trap_out) |->
    pulse_q == rom_patch_pkg::TRAP_CYCLES) else $error("trap pulse length");
  redir_src_a: assert property (jump_out.redirect |-> fetch_in.valid)
    else $error("redirect without fetch");
  cover property ($rose(enabled_out));
  cover property (jump_out.redirect);
  cover property (read_patched_out);
  cover property ($rose(trap_out));
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic rd;
    logic [19:0] addr;
    logic [1:0] size;
    logic ptr;
    logic [23:0] exp;
    logic hit;
  } row_type;
  logic clk_in, rstn_in, ce_in, patched, enabled, trap, pin, pin_oe;
  rom_patch_pkg::write_req_type wr_in;
  rom_patch_pkg::fetch_req_type fetch_in;
  rom_patch_pkg::read_req_type read_in;
  rom_patch_pkg::jump_type jump_out;
  logic [23:0] rom_data, read_data;
  logic [3:0] mode;
  logic [4:0] count;
  int err_count, compares;
  // Start addresses far apart, none on an idle instruction
  logic [43:0] banks [4] = '{{20'h0_C020, 24'h00_0400},
    {20'h0_D000, 24'hC3_CC33}, {20'h0_E000, 24'h00_0500},
    {20'h0_F000, 24'h11_2233}};
  row_type rows [12] = '{'{0, 20'h0_C020, 0, 0, 24'h00_0400, 1},
    '{0, 20'h0_C021, 0, 0, 0, 0}, '{0, 20'h0_E000, 0, 0, 24'h00_0500, 1},
    '{0, 20'h0_D000, 0, 0, 0, 0}, '{0, 20'h0_F000, 0, 0, 0, 0},
    '{1, 20'h0_D000, 1, 0, 24'h02_0133, 1},
    '{1, 20'h0_D000, 2, 0, 24'h02_CC33, 1},
    '{1, 20'h0_D000, 3, 0, 24'hC3_CC33, 1},
    '{1, 20'h0_D001, 3, 0, 24'h03_0201, 0},
    '{1, 20'h0_D000, 3, 1, 24'h02_0100, 0},
    '{1, 20'h0_C020, 3, 0, 24'h22_2120, 0},
    '{1, 20'h0_F000, 3, 0, 24'h11_2233, 1}};
  rom_patch_unit DUT (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .wr_in(wr_in), .fetch_in(fetch_in), .jump_out(jump_out),
    .read_in(read_in), .rom_data_in(rom_data), .read_data_out(read_data),
    .read_patched_out(patched), .enabled_out(enabled), .mode_out(mode),
    .write_count_out(count), .reset_pin_out(pin),
    .reset_pin_oe_out(pin_oe), .trap_out(trap));
  rom_image_model rom_i (.addr_in(read_in.addr), .data_out(rom_data));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic c);
    @(posedge clk_in);
    wr_in <= '{1'b1, a, d};
    ce_in <= c;
    @(posedge clk_in);
    wr_in <= '0;
    ce_in <= 1'b1;
    #1;
  endtask
  task automatic trap_try(input logic [19:0] a, input logic exp);
    int n;
    @(posedge clk_in);
    fetch_in <= '{1'b1, a};
    @(posedge clk_in);
    fetch_in <= '0;
    #1;
    chk(trap, exp, "trap");
    chk(pin_oe, exp, "pin drive");
    chk(pin, 1'b0, "pin level");
    n = 0;
    while (trap === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    if (exp) chk(n, rom_patch_pkg::TRAP_CYCLES, "pulse length");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Whole run is under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    stop_test;
  end
  initial begin
    logic [47:0] w;
    ce_in = 1'b1;
    rstn_in = 1'b0;
    wr_in = '0;
    fetch_in = '0;
    read_in = '0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    chk(count, 0, "count at reset");
    chk(enabled, 0, "enabled at reset");
    trap_try(20'h0_0300, 1);
    trap_try(20'h0_0F80, 1);
    $display("test reset done");
    wr(rom_patch_pkg::PATCH_CONTROL_ADDR, 8'h0A, 1);
    chk(mode, 4'hA, "mode bits");
    wr(rom_patch_pkg::PATCH_DATA_PORT_ADDR, 8'h20, 0);
    chk(count, 0, "write with clock enable low");
    for (int i = 0; i < 24; i++) begin
      w = {banks[i / 6][23:0], 4'h0, banks[i / 6][43:24]};
      wr(rom_patch_pkg::PATCH_DATA_PORT_ADDR, w[8 * (i % 6) +: 8], 1);
      chk(count, (i + 1) % 24, "write count");
      if (i == 4 || i == 6) chk(enabled, i == 6, "enable point");
    end
    $display("test load done");
    trap_try(20'h0_02C0, 0);
    trap_try(20'h0_02BF, 1);
    trap_try(20'h0_0000, 1);
    $display("test trap done");
    foreach (rows[i]) begin
      @(posedge clk_in);
      fetch_in <= '{!rows[i].rd, rows[i].addr};
      read_in <= '{rows[i].rd, rows[i].addr, rows[i].size, rows[i].ptr};
      #1;
      if (rows[i].rd) begin
        chk(read_data, rows[i].exp, "read data");
        chk(patched, rows[i].hit, "patched flag");
      end else begin
        chk(jump_out.redirect, rows[i].hit, "redirect");
        chk(jump_out.target, rows[i].exp[19:0], "jump target");
      end
    end
    @(posedge clk_in);
    fetch_in <= '0;
    read_in <= '0;
    $display("test table done");
    wr(rom_patch_pkg::PATCH_CONTROL_ADDR, 8'h00, 1);
    chk(enabled, 1, "enable sticky");
    // Reset is driven on the edge like every other input
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    chk(enabled, 0, "enable after reset");
    chk(count, 0, "count after reset");
    chk(mode, 4'h0, "mode after reset");
    @(posedge clk_in);
    fetch_in <= '{1'b1, 20'h0_C020};
    #1;
    chk(jump_out.redirect, 0, "redirect after reset");
    $display("test sticky done");
    stop_test;
  end
endmodule
bind rom_patch_unit rom_patch_unit_checker chk_i (.clk_in(clk_in),
  .rstn_in(rstn_in), .ce_in(ce_in), .wr_in(wr_in), .fetch_in(fetch_in),
  .jump_out(jump_out), .read_in(read_in), .rom_data_in(rom_data_in),
  .read_data_out(read_data_out), .read_patched_out(read_patched_out),
  .enabled_out(enabled_out), .mode_out(mode_out),
  .write_count_out(write_count_out), .trap_out(trap_out));
